/* File: dv/dpcd_chk.sv */
`timescale 1ns/100ps
module dpcd_chk
#(
   parameter int PROG_CYCLES = 50
)
(
   input wire logic         ref_clk_in,
   input wire logic         reset_n_in,
   input wire logic         link_clk_in,
   input wire logic         write_protect_n_in,
   input wire logic         reply_valid_out,
   input wire logic         reply_ack_out,
   input wire logic [7:0]   reply_data_out,
   input wire logic         prog_busy_out,
   input wire logic [7:0]   wiper0_pos_out,
   input wire logic [7:0]   wiper1_pos_out,
   input wire logic [255:0] wiper0_tap_out,
   input wire logic [255:0] wiper1_tap_out
);
   int busy_len;

   // length of the running program cycle, cleared when it ends
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
      if (!reset_n_in)
         busy_len <= 0;
      else if (prog_busy_out)
         busy_len <= busy_len + 1;
      else
         busy_len <= 0;

   // a reply strobe is exactly one link cycle wide
   sequence s_reply;
      reply_valid_out ##1 !reply_valid_out;
   endsequence

   property p_tap0;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      wiper0_tap_out == (256'h1 << wiper0_pos_out);
   endproperty
   property p_tap1;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      wiper1_tap_out == (256'h1 << wiper1_pos_out);
   endproperty
   property p_busy_len;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      $fell(prog_busy_out) |-> busy_len == PROG_CYCLES;
   endproperty
   property p_busy_max;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      busy_len <= PROG_CYCLES;
   endproperty
   property p_busy_wp;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(prog_busy_out) |-> write_protect_n_in;
   endproperty
   // nothing else may reach the wipers while programming
   property p_busy_hold;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      prog_busy_out |=> $stable(wiper0_pos_out) && $stable(wiper1_pos_out);
   endproperty
   property p_reply_pulse;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      $rose(reply_valid_out) |-> s_reply;
   endproperty
   property p_reply_hold;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      !reply_valid_out |-> $stable(reply_ack_out) && $stable(reply_data_out);
   endproperty

   a_tap0: assert property (p_tap0) else $error("tap0 off position");
   a_tap1: assert property (p_tap1) else $error("tap1 off position");
   a_busy_len: assert property (p_busy_len) else $error("busy length");
   a_busy_max: assert property (p_busy_max) else $error("busy too long");
   a_busy_wp: assert property (p_busy_wp) else $error("program when wp");
   a_busy_hold: assert property (p_busy_hold) else $error("wiper moved");
   a_reply_pulse: assert property (p_reply_pulse) else $error("reply");
   a_reply_hold: assert property (p_reply_hold) else $error("reply held");
endmodule // dpcd_chk

bind dpcd_decoder dpcd_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
   .link_clk_in(link_clk_in), .write_protect_n_in(write_protect_n_in),
   .reply_valid_out(reply_valid_out), .reply_ack_out(reply_ack_out),
   .reply_data_out(reply_data_out), .prog_busy_out(prog_busy_out),
   .wiper0_pos_out(wiper0_pos_out), .wiper1_pos_out(wiper1_pos_out),
   .wiper0_tap_out(wiper0_tap_out), .wiper1_tap_out(wiper1_tap_out));

/* File: dv/dpcd_master.sv */
`timescale 1ns/100ps
module dpcd_master
(
   output logic       link_clk_out,
   output logic       ev_valid_out,
   output logic [1:0] ev_kind_out,
   output logic [7:0] ev_data_out,
   input wire logic   reply_valid_in,
   input wire logic   reply_ack_in,
   input wire logic [7:0] reply_data_in
);
   bit run = 1;
   initial
   begin
      link_clk_out = 0;
      ev_valid_out = 0;
      ev_kind_out = 2'h0;
      ev_data_out = 8'h5a;
   end

   // link clock runs through power-up reset and inside frames, parking
   // low between them; offset keeps its phase away from the core clock
   initial #3 forever
   begin
      if (run || link_clk_out)
         link_clk_out = ~link_clk_out;
      #16;
   end

   // one event per strobe; data is scrambled once released
   task automatic ev(input logic [1:0] k, input logic [7:0] d);
      @(posedge link_clk_out);
      ev_valid_out <= 1'b1;
      ev_kind_out <= k;
      ev_data_out <= d;
      @(posedge link_clk_out);
      ev_valid_out <= 1'b0;
      ev_data_out <= ~d;
   endtask

   task automatic put_byte(input logic [7:0] b, output logic ack,
                           output logic [7:0] rd);
      int n;
      n = 0;
      ev(2'b01, b);
      do
      begin
         @(posedge link_clk_out);
         n++;
      end
      while (reply_valid_in !== 1'b1 && n < 40);
      ack = (n < 40) ? reply_ack_in : 1'bx;
      rd = reply_data_in;
   endtask

   task automatic frame_begin();
      run = 1;
      ev(2'b00, 8'h00);
   endtask

   task automatic frame_end();
      ev(2'b10, 8'h00);
      repeat (4) @(posedge link_clk_out);
      run = 0;
   endtask

   task automatic step(input logic up);
      ev(2'b11, {7'h00, up});
   endtask
endmodule // dpcd_master

/* File: dv/dual_pot_command_decoder_tb.sv */
`timescale 1ns/100ps
module dual_pot_command_decoder_tb;
   import dpcd_pkg::*;
   localparam int PC = 50;
   logic ref_clk_in = 0, reset_n_in, wp_n = 1;
   logic [3:0] pins;
   wire lclk, evv, rv, ra, busy;
   wire [1:0] evk;
   wire [7:0] evd, rdat, pos [2];
   int mismatches = 0, n_checks = 0, cycles = 0, seed = 95, w, r, i;
   logic ka, ki, kd;
   logic [7:0] rd, d, a, set_m [2][4], wip_m [2];

   dpcd_decoder #(.PROG_CYCLES(PC)) uut (.ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in), .link_clk_in(lclk), .ev_valid_in(evv),
      .ev_kind_in(evk), .ev_data_in(evd), .addr_select_pins_in(pins),
      .write_protect_n_in(wp_n), .reply_valid_out(rv), .reply_ack_out(ra),
      .reply_data_out(rdat), .prog_busy_out(busy), .wiper0_pos_out(pos[0]),
      .wiper1_pos_out(pos[1]), .wiper0_tap_out(), .wiper1_tap_out());
   dpcd_master m (.link_clk_out(lclk), .ev_valid_out(evv), .ev_kind_out(evk),
      .ev_data_out(evd), .reply_valid_in(rv), .reply_ack_in(ra),
      .reply_data_in(rdat));

   always #4 ref_clk_in = ~ref_clk_in;

   task automatic print_verdict();
      if (mismatches == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] ins(input logic [3:0] op,
                                      input int x, input int y);
      return {op, x[1:0], 1'b0, y[0]};
   endfunction

   function automatic logic [7:0] nxt(input logic [7:0] p, input logic up);
      if (up)
         return (p == 8'hff) ? p : p + 8'h01;
      return (p == 8'h00) ? p : p - 8'h01;
   endfunction

   // wait out one program cycle or delayed wiper update
   task automatic settle();
      repeat (PC + 20) @(posedge ref_clk_in);
   endtask

   task automatic cmd(input logic [7:0] i8, input bit wd, input logic [7:0] dv);
      logic [7:0] x;
      m.frame_begin();
      m.put_byte({DEVICE_TYPE_ID, pins}, ka, x);
      m.put_byte(i8, ki, rd);
      kd = 1'b1;
      if (wd)
      begin
         m.put_byte(dv, kd, x);
         chk({7'h0, busy}, 8'h00);
      end
      m.frame_end();
   endtask

   initial
   begin
      reset_n_in <= 1'b0; // real edge so both domains reset at time 0
      pins = 4'($random(seed));
      repeat (2) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      for (i = 0; i < 8; i++)
      begin
         d = 8'($random(seed));
         set_m[i/4][i%4] = d;
         cmd(ins(OP_WR_SET, i % 4, i / 4), 1, d);
         chk({ka, ki, kd}, 8'h07);
         m.frame_begin();
         m.put_byte({DEVICE_TYPE_ID, pins}, ka, rd);
         m.frame_end();
         chk({7'h0, ka}, 8'h00);
         settle();
      end
      reset_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      for (w = 0; w < 2; w++)
      begin
         wip_m[w] = set_m[w][0];
         chk(pos[w], wip_m[w]);
      end
      for (i = 0; i < 8; i++)
      begin
         cmd(ins(OP_RD_SET, i % 4, i / 4), 0, 8'h00);
         chk(rd, set_m[i/4][i%4]);
      end
      for (i = 0; i < 6; i++)
      begin
         w = i % 2;
         d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
         wip_m[w] = d;
         cmd(ins(OP_WR_WIPER, 0, w), 1, d);
         repeat (4) @(posedge ref_clk_in);
         chk(pos[w], d);
         cmd(ins(OP_RD_WIPER, 0, w), 0, 8'h00);
         chk(rd, d);
      end
      for (w = 0; w < 2; w++)
      begin
         d = w ? 8'hfe : 8'h01;
         cmd(ins(OP_WR_WIPER, 0, w), 1, d);
         m.frame_begin();
         m.put_byte({DEVICE_TYPE_ID, pins}, ka, rd);
         m.put_byte(ins(OP_STEP, 0, w), ki, rd);
         repeat (3)
         begin
            m.step(w[0]);
            d = nxt(d, w[0]);
         end
         m.frame_end();
         wip_m[w] = d;
         chk(pos[w], d);
      end
      r = $unsigned($random(seed)) % 4;
      cmd(ins(OP_COPY_TO_SET, r, 1), 0, 8'h00);
      settle();
      set_m[1][r] = wip_m[1];
      cmd(ins(OP_RD_SET, r, 1), 0, 8'h00);
      chk(rd, set_m[1][r]);
      r = (r + 1) % 4;
      cmd(ins(OP_GANG_TO_SET, r, 0), 0, 8'h00);
      settle();
      for (w = 0; w < 2; w++)
      begin
         set_m[w][r] = wip_m[w];
         cmd(ins(OP_RD_SET, r, w), 0, 8'h00);
         chk(rd, set_m[w][r]);
      end
      cmd(ins(OP_WR_WIPER, 0, 0), 1, ~set_m[0][2]);
      cmd(ins(OP_COPY_TO_WIP, 2, 0), 0, 8'h00);
      chk(pos[0], ~set_m[0][2]);
      settle();
      chk(pos[0], set_m[0][2]);
      r = (r + 2) % 4;
      cmd(ins(OP_GANG_TO_WIP, r, 0), 0, 8'h00);
      settle();
      chk(pos[0], set_m[0][r]);
      chk(pos[1], set_m[1][r]);
      wp_n <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      cmd(ins(OP_WR_SET, 1, 0), 1, ~set_m[0][1]);
      chk({7'h0, kd}, 8'h00);
      settle();
      wp_n <= 1'b1;
      cmd(ins(OP_RD_SET, 1, 0), 0, 8'h00);
      chk(rd, set_m[0][1]);
      for (i = 0; i < 2; i++)
      begin
         a = i ? {DEVICE_TYPE_ID, ~pins} : {~DEVICE_TYPE_ID, pins};
         m.frame_begin();
         m.put_byte(a, ka, rd);
         m.frame_end();
         chk({7'h0, ka}, 8'h00);
      end
      print_verdict();
   end
endmodule // dual_pot_command_decoder_tb

/* File: rtl/dpcd_decoder.sv */
`timescale 1ns/100ps
// Operation
// (RULE1) address byte comes first; its upper nibble must equal the type id
// (RULE2) lower address nibble must equal the address-select pins
// (RULE3) instruction byte: opcode, setting index, wiper select
// (RULE4) setting index 0 picks first stored setting, 1 the second
// (RULE5) two 8-bit wiper positions, each decoded to one of 256 taps
// (RULE6) at power-up each wiper loads from its first stored setting
// (RULE7) four 8-bit stored settings per wiper; updates finish within 10 ms
// (RULE8) opcode 1001 returns the selected wiper position
// (RULE9) opcode 1010 writes the data byte into the selected wiper position
// (RULE10) opcode 1011 returns the selected stored setting
// (RULE11) opcode 1100 writes the data byte into the selected stored setting
// (RULE12) opcode 1101 copies a stored setting into its wiper position
// (RULE13) opcode 1110 copies a wiper position into a stored setting
// (RULE14) opcode 0001 loads both wipers from stored settings at the index
// (RULE15) opcode 1000 stores both wipers into settings at the index
// (RULE16) opcode 0010 enters step mode for the selected wiper
// (RULE17) read and write commands span three bytes; reads here end at the instruction byte, whose reply carries the data
// (RULE18) copy commands span two bytes, then stop
// (RULE19) wiper-to-setting copy is a nonvolatile write taking program time
// (RULE20) copied wiper value reaches the taps only after program time
// (RULE21) step with data high moves wiper one tap up
// (RULE22) step with data low moves wiper one tap down
// (RULE23) setting index 2 and 3 pick third and fourth stored settings
// (RULE24) stepping saturates at 0 and 255, never wraps
// (RULE25) during a program cycle the address byte is not acknowledged
// (RULE26) write-protect low: data byte not acknowledged, nothing programmed
// (RULE27) setting programming starts only at the stop that ends the command
module dpcd_decoder
   import dpcd_pkg::*;
#(
   parameter int PROG_CYCLES = TWR_CYCLES
)
(
   input  wire logic         ref_clk_in,
   input  wire logic         reset_n_in,
   input  wire logic         link_clk_in,
   input  wire logic         ev_valid_in,
   input  wire logic [1:0]   ev_kind_in,
   input  wire logic [7:0]   ev_data_in,
   input  wire logic [3:0]   addr_select_pins_in,
   input  wire logic         write_protect_n_in,
   output logic              reply_valid_out,
   output logic              reply_ack_out,
   output logic      [7:0]   reply_data_out,
   output logic              prog_busy_out,
   output logic      [7:0]   wiper0_pos_out,
   output logic      [7:0]   wiper1_pos_out,
   output logic      [255:0] wiper0_tap_out,
   output logic      [255:0] wiper1_tap_out
);

   // refuse a program time the timer cannot hold
   if (PROG_CYCLES < 1 || PROG_CYCLES >= 2**TIMER_W)
   begin : g_bad_prog
      $error("PROG_CYCLES out of range");
   end

   // one-hot tap decode
   function automatic logic [255:0] tap_decode(input logic [7:0] pos);
      tap_decode = 256'h1 << pos;
   endfunction

   // legal field combinations per opcode
   function automatic logic ins_legal(input logic [7:0] b);
      logic [3:0] o;
      o = b[OPC_LSB +: 4];
      case (o)
         OP_RD_WIPER, OP_WR_WIPER, OP_STEP:
            ins_legal = (b[IDX_LSB +: 2] == 2'h0) && !b[WSEL_LSB + 1];
         OP_RD_SET, OP_WR_SET, OP_COPY_TO_WIP, OP_COPY_TO_SET:
            ins_legal = !b[WSEL_LSB + 1];
         OP_GANG_TO_WIP, OP_GANG_TO_SET:
            ins_legal = (b[WSEL_LSB +: 2] == 2'h0);
         default:
            ins_legal = 1'b0;
      endcase
   endfunction

   // nonvolatile-write class of opcode
   function automatic logic is_nv_write(input logic [3:0] o);
      is_nv_write = (o == OP_WR_SET) || (o == OP_COPY_TO_SET) ||
                    (o == OP_GANG_TO_SET);
   endfunction

   // link domain: capture each framer event and flag it by toggle
   logic       ev_tgl;
   logic [1:0] ev_kind_q;
   logic [7:0] ev_data_q;
   logic       rep_tgl_l;
   logic       rep_seen;
   logic       reply_tgl;
   logic       reply_ack;
   logic [7:0] reply_data;

   always_ff @(posedge link_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ev_tgl    <= 1'b0;
         ev_kind_q <= 2'h0;
         ev_data_q <= 8'h00;
      end
      else if (ev_valid_in)
      begin
         ev_tgl    <= ~ev_tgl;
         ev_kind_q <= ev_kind_in;
         ev_data_q <= ev_data_in;
      end
   end

   dpcd_sync #(.W(1)) u_rep_sync (
      .clk_in     (link_clk_in),
      .reset_n_in (reset_n_in),
      .d_in       (reply_tgl),
      .q_out      (rep_tgl_l)
   );

   // core answer words are stable once their toggle arrives here
   always_ff @(posedge link_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rep_seen        <= 1'b0;
         reply_valid_out <= 1'b0;
         reply_ack_out   <= 1'b0;
         reply_data_out  <= 8'h00;
      end
      else
      begin
         rep_seen        <= rep_tgl_l;
         reply_valid_out <= rep_tgl_l ^ rep_seen;
         if (rep_tgl_l ^ rep_seen)
         begin
            reply_ack_out  <= reply_ack;
            reply_data_out <= reply_data;
         end
      end
   end

   // core domain: synchronise event toggle and strapped pins
   logic       ev_tgl_s;
   logic       ev_seen;
   logic [4:0] pins_s;

   dpcd_sync #(.W(1)) u_ev_sync (
      .clk_in     (ref_clk_in),
      .reset_n_in (reset_n_in),
      .d_in       (ev_tgl),
      .q_out      (ev_tgl_s)
   );

   dpcd_sync #(.W(5)) u_pin_sync (
      .clk_in     (ref_clk_in),
      .reset_n_in (reset_n_in),
      .d_in       ({write_protect_n_in, addr_select_pins_in}),
      .q_out      (pins_s)
   );

   dpcd_state_e st;
   dpcd_state_e next_st;
   logic [7:0]  ins;
   logic [7:0]  next_ins;
   logic [7:0]  wbuf;
   logic [7:0]  next_wbuf;
   logic        pend;
   logic        next_pend;
   logic [1:0]  ex_step;
   logic [1:0]  next_ex_step;
   logic        booting;
   logic        next_booting;
   logic        next_reply_tgl;
   logic        next_reply_ack;
   logic [7:0]  next_reply_data;
   logic [7:0]  wiper      [2];
   logic [7:0]  next_wiper [2];
   logic [7:0]  applied    [2];
   logic [TIMER_W-1:0] tmr;
   logic        tmr_nv;
   logic        tmr_hold;
   logic        tmr_start;
   logic        mem_we;
   logic [2:0]  mem_waddr;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;

   // field decode of the latched instruction and the incoming byte
   wire         ev_new   = ev_tgl_s ^ ev_seen;
   wire [3:0]   opc      = ins[OPC_LSB +: 4];
   wire [1:0]   idx      = ins[IDX_LSB +: 2];
   wire         wsel     = ins[WSEL_LSB];
   wire [3:0]   b_opc    = ev_data_q[OPC_LSB +: 4];
   wire         b_wsel   = ev_data_q[WSEL_LSB];
   wire         wp_n     = pins_s[4];
   wire         gang     = (opc == OP_GANG_TO_WIP) || (opc == OP_GANG_TO_SET);
   wire         nv_op    = is_nv_write(opc);
   wire         exw      = gang ? ex_step[0] : wsel;
   wire         prev_w   = gang ? ex_step[1] : wsel;
   wire [1:0]   ex_last  = gang ? (nv_op ? 2'h1 : 2'h2)
                                : (nv_op ? 2'h0 : 2'h1);
   wire         addr_hit = (ev_data_q[ID_LSB +: 4] == DEVICE_TYPE_ID) && // RULE1
                           (ev_data_q[3:0] == pins_s[3:0]) &&           // RULE2
                           !tmr_nv;                                     // RULE25
   wire         b_legal  = ins_legal(ev_data_q);                        // RULE3
   wire         freeze   = tmr_hold ||
                           (st == ST_EXEC && !booting && !nv_op);       // RULE20
   wire [2:0]   mem_raddr = (st == ST_INSTR) ?
                            {b_wsel, ev_data_q[IDX_LSB +: 2]} :
                            {exw, idx};                 // RULE4 RULE23

   // stored settings, index = {wiper, setting index}
   dpcd_setting_mem #(.DW(8), .AW(3)) u_mem (
      .clk_in    (ref_clk_in),
      .we_in     (mem_we),
      .waddr_in  (mem_waddr),
      .wdata_in  (mem_wdata),
      .raddr_in  (mem_raddr),
      .rdata_out (mem_rdata)
   );

   // sequencer: one event handled per toggle; exec runs after the stop
   always_comb
   begin
      next_st         = st;
      next_ins        = ins;
      next_wbuf       = wbuf;
      next_pend       = pend;
      next_ex_step    = ex_step;
      next_booting    = booting;
      next_reply_tgl  = reply_tgl;
      next_reply_ack  = reply_ack;
      next_reply_data = reply_data;
      next_wiper      = wiper;
      tmr_start       = 1'b0;
      mem_we          = 1'b0;
      mem_waddr       = {exw, idx};
      mem_wdata       = (opc == OP_WR_SET) ? wbuf : wiper[exw];
      case (st)
         ST_EXEC:
         begin
            if (nv_op)
               mem_we = 1'b1;                      // RULE11 RULE13 RULE15
            else if (ex_step != 2'h0)
               next_wiper[prev_w] = mem_rdata;     // RULE6 RULE12 RULE14
            next_ex_step = ex_step + 2'h1;
            if (ex_step == ex_last)
            begin
               next_st      = ST_IDLE;
               tmr_start    = !booting;            // RULE19 RULE7
               next_booting = 1'b0;
               next_pend    = 1'b0;
            end
         end
         ST_RDSET:
         begin
            next_reply_tgl  = ~reply_tgl;
            next_reply_ack  = 1'b1;
            next_reply_data = mem_rdata;           // RULE10
            next_st         = ST_WAIT;
         end
         default:
         begin
            if (ev_new)
            begin
               case (dpcd_ev_e'(ev_kind_q))
                  EV_START:
                  begin
                     next_st   = ST_ADDR;
                     next_pend = 1'b0;
                  end
                  EV_STOP:
                  begin
                     next_ex_step = 2'h0;
                     next_st      = pend ? ST_EXEC : ST_IDLE; // RULE27
                  end
                  EV_STEP:
                  begin
                     if (st == ST_STEP && ev_data_q[0] && wiper[wsel] != WIPER_MAX)
                        next_wiper[wsel] = wiper[wsel] + 8'h01; // RULE21 RULE24
                     else if (st == ST_STEP && !ev_data_q[0] &&
                              wiper[wsel] != WIPER_MIN)
                        next_wiper[wsel] = wiper[wsel] - 8'h01; // RULE22 RULE24
                  end
                  default:
                  begin
                     next_reply_tgl = ~reply_tgl;
                     next_reply_ack = 1'b0;
                     next_st        = ST_WAIT;
                     if (st == ST_ADDR)
                     begin
                        next_reply_ack = addr_hit;               // RULE1 RULE2
                        next_st        = addr_hit ? ST_INSTR : ST_IDLE;
                     end
                     else if (st == ST_INSTR && b_legal)
                     begin
                        next_ins       = ev_data_q;
                        next_reply_ack = 1'b1;
                        case (b_opc)
                           OP_RD_WIPER:
                              next_reply_data = wiper[b_wsel];   // RULE8
                           OP_WR_WIPER, OP_WR_SET:
                              next_st = ST_DATA;                 // RULE17
                           OP_RD_SET:
                           begin
                              next_reply_tgl = reply_tgl;
                              next_st        = ST_RDSET;
                           end
                           OP_STEP:
                              next_st = ST_STEP;                 // RULE16
                           default:
                              next_pend = wp_n || !is_nv_write(b_opc); // RULE18
                        endcase
                     end
                     else if (st == ST_DATA && opc == OP_WR_WIPER)
                     begin
                        next_reply_ack = 1'b1;
                        next_wiper[wsel] = ev_data_q;            // RULE9
                     end
                     else if (st == ST_DATA)
                     begin
                        next_reply_ack = wp_n;                   // RULE26
                        next_pend      = wp_n;
                        next_wbuf      = ev_data_q;
                     end
                  end
               endcase
            end
         end
      endcase
   end

   // sequencer registers; reset starts the power-up recall
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st         <= ST_EXEC;
         ins        <= BOOT_INSTR;
         wbuf       <= 8'h00;
         pend       <= 1'b0;
         ex_step    <= 2'h0;
         booting    <= 1'b1;
         ev_seen    <= 1'b0;
         reply_tgl  <= 1'b0;
         reply_ack  <= 1'b0;
         reply_data <= 8'h00;
         wiper[0]   <= WIPER_MIN;
         wiper[1]   <= WIPER_MIN;
      end
      else
      begin
         st         <= next_st;
         ins        <= next_ins;
         wbuf       <= next_wbuf;
         pend       <= next_pend;
         ex_step    <= next_ex_step;
         booting    <= next_booting;
         ev_seen    <= ev_tgl_s;
         reply_tgl  <= next_reply_tgl;
         reply_ack  <= next_reply_ack;
         reply_data <= next_reply_data;
         wiper      <= next_wiper;
      end
   end

   // program timer; nv flag blocks addressing, hold delays the taps
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tmr      <= '0;
         tmr_nv   <= 1'b0;
         tmr_hold <= 1'b0;
      end
      else if (tmr_start)
      begin
         tmr      <= TIMER_W'(PROG_CYCLES - 1); // load cycle counts too
         tmr_nv   <= nv_op;                        // RULE25
         tmr_hold <= !nv_op;                       // RULE20
      end
      else if (tmr != '0)
         tmr <= tmr - TIMER_W'(1);
      else
      begin
         tmr_nv   <= 1'b0;
         tmr_hold <= 1'b0;
      end
   end

   assign prog_busy_out = tmr_nv;

   // tap drive; a copy into a wiper waits out the program time
   for (genvar w = 0; w < 2; w++)
   begin : g_tap
      logic [255:0] tap;
      always_ff @(posedge ref_clk_in or negedge reset_n_in)
      begin
         if (!reset_n_in)
         begin
            applied[w] <= WIPER_MIN;
            tap        <= tap_decode(WIPER_MIN);
         end
         else if (!freeze)
         begin
            applied[w] <= wiper[w];
            tap        <= tap_decode(wiper[w]);    // RULE5
         end
      end
   end

   assign wiper0_pos_out = applied[0];
   assign wiper1_pos_out = applied[1];
   assign wiper0_tap_out = g_tap[0].tap;
   assign wiper1_tap_out = g_tap[1].tap;

endmodule // dpcd_decoder

/* File: rtl/dpcd_pkg.sv */
package dpcd_pkg;

   // core clock and nonvolatile program timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int TWR_MS        = 5;
   localparam int NS_PER_MS     = 1000000;
   localparam int TWR_CYCLES    = TWR_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int TIMER_W       = 20;

   // device-type identifier, value arbitrary
   localparam logic [3:0] DEVICE_TYPE_ID = 4'h6;

   // byte field positions
   localparam int ID_LSB   = 4;
   localparam int OPC_LSB  = 4;
   localparam int IDX_LSB  = 2;
   localparam int WSEL_LSB = 0;

   // wiper limits
   localparam logic [7:0] WIPER_MIN = 8'h00;
   localparam logic [7:0] WIPER_MAX = 8'hff;

   // opcodes
   localparam logic [3:0] OP_RD_WIPER    = 4'h9;
   localparam logic [3:0] OP_WR_WIPER    = 4'ha;
   localparam logic [3:0] OP_RD_SET      = 4'hb;
   localparam logic [3:0] OP_WR_SET      = 4'hc;
   localparam logic [3:0] OP_COPY_TO_WIP = 4'hd;
   localparam logic [3:0] OP_COPY_TO_SET = 4'he;
   localparam logic [3:0] OP_GANG_TO_WIP = 4'h1;
   localparam logic [3:0] OP_GANG_TO_SET = 4'h8;
   localparam logic [3:0] OP_STEP        = 4'h2;

   // instruction used for the power-up recall of the first stored setting
   localparam logic [7:0] BOOT_INSTR = {OP_GANG_TO_WIP, 4'h0};

   // link events delivered by the bit framer
   typedef enum logic [1:0] {
      EV_START = 2'b00,
      EV_BYTE  = 2'b01,
      EV_STOP  = 2'b10,
      EV_STEP  = 2'b11
   } dpcd_ev_e;

   // command sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_INSTR = 3'b010,
      ST_DATA  = 3'b011,
      ST_STEP  = 3'b100,
      ST_WAIT  = 3'b101,
      ST_RDSET = 3'b110,
      ST_EXEC  = 3'b111
   } dpcd_state_e;

endpackage

/* File: rtl/dpcd_setting_mem.sv */
`timescale 1ns/100ps
module dpcd_setting_mem
#(
   parameter int DW = 8,
   parameter int AW = 3
)
(
   input  wire logic          clk_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [DW-1:0] wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [DW-1:0] rdata_out
);

   // a blank array reads as zero, so the power-up recall is defined
   logic [DW-1:0] mem [2**AW] = '{default: '0};

   // no reset: contents model nonvolatile storage and survive reset
   always_ff @(posedge clk_in)
   begin
      if (we_in)
         mem[waddr_in] <= wdata_in;
      rdata_out <= mem[raddr_in];
   end

endmodule // dpcd_setting_mem

/* File: rtl/dpcd_sync.sv */
`timescale 1ns/100ps
module dpcd_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk_in,
   input  wire logic         reset_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta;

   // two-stage synchroniser; only the second stage is read outside
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         meta  <= '0;
         q_out <= '0;
      end
      else
      begin
         meta  <= d_in;
         q_out <= meta;
      end
   end

endmodule // dpcd_sync
